/* logic/external_line_event_ctrl.sv */
// Twenty-line edge interrupt and event controller with AXI4-Lite registers.
// Assumes pins and internal sources are asynchronous to aclk, and that the
// processor interrupt controller and wake logic take level/pulse outputs.
//
// Notes on behaviour
// RL1: Twenty independent lines, each with its own edge detector.
// RL2: Eighteen lines come from pins, two from on-chip modules.
// RL3: Per-line rise and fall enables; both set gives double-edge detection.
// RL4: Interrupt request passes only while the line's interrupt mask is 1.
// RL5: Enabled edge on unmasked line raises request and sets pending flag.
// RL6: Writing 1 to a pending bit clears it; writing 0 does nothing.
// RL7: Event produced only while event mask is 1, same edge enables.
// RL8: Enabled edge on unmasked event line gives one pulse, pending untouched.
// RL9: Writing 1 to a software request bit triggers that line, masks apply.
// RL10: Software sets masks before writing software request bits.
// RL11: Interrupt and event outputs serve as low-power wake-up sources.
// RL12: Software enables the pin-select block clock before line setup.
// RL13: Software enables the matching channel in the nested controller.
// RL14: Lines 0-15 are port A pins 0-15; lines 16, 17 port B 0, 1.
// RL15: Line 18 is supply monitor output; line 19 timer wake event.
// RL16: Three grouped interrupt outputs: lines 1:0, 3:2, and 17:4; lines 18 and 19 each have their own.
// RL17: Pending stays set until cleared; edges found on the bus clock.
// RL18: All line bits reset to zero; bits 31:20 read as zero.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "line_event_defs.svh"

module external_line_event_ctrl
    import line_event_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`PORT_A_LINES-1:0] port_a_pin,
    input wire logic [`PORT_B_LINES-1:0] port_b_pin,
    input wire logic supply_monitor_out,
    input wire logic basic_wake_timer_event,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic irq_lines_1_0,
    output logic irq_lines_3_2,
    output logic irq_lines_17_4,
    output logic irq_supply_monitor,
    output logic irq_wake_timer,
    output logic [`LINE_COUNT-1:0] line_event_pulse,
    output logic wake_irq_request,
    output logic wake_event_pulse,
    output logic status_irq
);

    localparam int N = `LINE_COUNT;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] prev;
        logic [N-1:0] imask;
        logic [N-1:0] emask;
        logic [N-1:0] rise_en;
        logic [N-1:0] fall_en;
        logic [N-1:0] swreq;
        logic [N-1:0] pend;
        logic [`ST_WIDTH-1:0] status;
        logic [`ST_WIDTH-1:0] stmask;
        logic irq_1_0;
        logic irq_3_2;
        logic irq_17_4;
        logic irq_18;
        logic irq_19;
        logic [N-1:0] evt;
        logic wake_irq;
        logic wake_evt;
        logic st_irq;
        wr_state_t wr_state;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        rd_state_t rd_state;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    localparam state_t RESET_STATE = '{
        wr_state: WR_IDLE,
        rd_state: RD_IDLE,
        default: '0
    };

    state_t s_r;
    state_t s_nxt;

    // Byte-lane merge of a write into a line-wide register
    function automatic logic [N-1:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return m[N-1:0];
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [N-1:0] raw;
        logic [N-1:0] rise;
        logic [N-1:0] fall;
        logic [N-1:0] trig;
        logic [N-1:0] int_set;
        logic [N-1:0] sw_fire;
        logic [N-1:0] pend_clr;
        logic [N-1:0] wm;
        logic [N-1:0] wd;
        logic [`ST_WIDTH-1:0] st_clr;
        logic [`ST_WIDTH-1:0] st_set;
        raw = '0;
        rise = '0;
        fall = '0;
        trig = '0;
        int_set = '0;
        sw_fire = '0;
        pend_clr = '0;
        wm = '0;
        wd = '0;
        st_clr = '0;
        st_set = '0;
        s_nxt = s_r;

        // RL14 port pin order
        raw[`PORT_A_LINES-1:0] = port_a_pin;
        raw[`PORT_A_LINES+`PORT_B_LINES-1:`PORT_A_LINES] = port_b_pin;
        // RL15 internal sources
        raw[18] = supply_monitor_out;
        raw[19] = basic_wake_timer_event;

        // RL2 pins and modules alike pass two flops before use
        s_nxt.sync1 = raw;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;

        // RL1 one detector per line, clocked by aclk (RL17)
        rise = s_r.sync2 & ~s_r.prev;
        fall = ~s_r.sync2 & s_r.prev;

        // ************************************************************
        // Write channel
        // ************************************************************
        case (s_r.wr_state)
            WR_IDLE: begin
                if (s_axi_awvalid && s_r.awready) begin
                    s_nxt.aw_got = 1'b1;
                    s_nxt.awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_r.wready) begin
                    s_nxt.w_got = 1'b1;
                    s_nxt.wdata = s_axi_wdata;
                    s_nxt.wstrb = s_axi_wstrb;
                end
                if (s_r.aw_got && s_r.w_got) begin
                    wm = lane_mask(s_r.wstrb);
                    wd = s_r.wdata[N-1:0];
                    s_nxt.bvalid = 1'b1;
                    s_nxt.bresp = `RESP_OKAY;
                    s_nxt.wr_state = WR_RESP;
                    if (s_r.awaddr == `OFS_INTERRUPT_MASK) begin
                        s_nxt.imask = (s_r.imask & ~wm) | (wd & wm);
                    end else if (s_r.awaddr == `OFS_EVENT_MASK) begin
                        s_nxt.emask = (s_r.emask & ~wm) | (wd & wm);
                    end else if (s_r.awaddr == `OFS_RISING_EDGE_ENABLE) begin
                        s_nxt.rise_en = (s_r.rise_en & ~wm) | (wd & wm);
                    end else if (s_r.awaddr == `OFS_FALLING_EDGE_ENABLE) begin
                        s_nxt.fall_en = (s_r.fall_en & ~wm) | (wd & wm);
                    end else if (s_r.awaddr == `OFS_SOFTWARE_REQUEST) begin
                        // RL9 each written one fires its line once
                        sw_fire = wd & wm;
                        s_nxt.swreq = s_r.swreq | sw_fire;
                    end else if (s_r.awaddr == `OFS_PENDING_FLAGS) begin
                        // RL6 ones clear, zeros ignored
                        pend_clr = wd & wm;
                    end else if (s_r.awaddr == `OFS_IRQ_STATUS_MASK) begin
                        if (s_r.wstrb[0]) begin
                            s_nxt.stmask = s_r.wdata[`ST_WIDTH-1:0];
                        end
                    end else if (s_r.awaddr == `OFS_IRQ_STATUS) begin
                        // Read-only: write accepted and dropped
                        s_nxt.bresp = `RESP_OKAY;
                    end else begin
                        s_nxt.bresp = `RESP_SLVERR;
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.wr_state = WR_IDLE;
                end
            end
            default: begin
                s_nxt.wr_state = WR_IDLE;
            end
        endcase
        s_nxt.awready = (s_nxt.wr_state == WR_IDLE) && !s_nxt.aw_got;
        s_nxt.wready = (s_nxt.wr_state == WR_IDLE) && !s_nxt.w_got;

        // ************************************************************
        // Read channel
        // ************************************************************
        case (s_r.rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid && s_r.arready) begin
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rd_state = RD_DATA;
                    s_nxt.rresp = `RESP_OKAY;
                    s_nxt.rdata = 32'h00000000;
                    // RL18 upper bits always zero
                    if (s_axi_araddr == `OFS_INTERRUPT_MASK) begin
                        s_nxt.rdata[N-1:0] = s_r.imask;
                    end else if (s_axi_araddr == `OFS_EVENT_MASK) begin
                        s_nxt.rdata[N-1:0] = s_r.emask;
                    end else if (s_axi_araddr == `OFS_RISING_EDGE_ENABLE) begin
                        s_nxt.rdata[N-1:0] = s_r.rise_en;
                    end else if (s_axi_araddr == `OFS_FALLING_EDGE_ENABLE) begin
                        s_nxt.rdata[N-1:0] = s_r.fall_en;
                    end else if (s_axi_araddr == `OFS_SOFTWARE_REQUEST) begin
                        s_nxt.rdata[N-1:0] = s_r.swreq;
                    end else if (s_axi_araddr == `OFS_PENDING_FLAGS) begin
                        s_nxt.rdata[N-1:0] = s_r.pend;
                    end else if (s_axi_araddr == `OFS_IRQ_STATUS) begin
                        s_nxt.rdata[`ST_WIDTH-1:0] = s_r.status;
                        st_clr = s_r.status;
                    end else if (s_axi_araddr == `OFS_IRQ_STATUS_MASK) begin
                        s_nxt.rdata[`ST_WIDTH-1:0] = s_r.stmask;
                    end else begin
                        s_nxt.rresp = `RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rd_state = RD_IDLE;
                end
            end
            default: begin
                s_nxt.rd_state = RD_IDLE;
            end
        endcase
        s_nxt.arready = (s_nxt.rd_state == RD_IDLE);

        // ************************************************************
        // Trigger, pending and event logic
        // ************************************************************
        // RL3 independent rise and fall enables
        trig = (rise & s_r.rise_en) | (fall & s_r.fall_en) | sw_fire;
        // RL4 interrupt mask gates requests
        int_set = trig & s_r.imask;
        // RL5 set pending; a set in the clear cycle wins (RL17 sticky)
        s_nxt.pend = (s_r.pend & ~pend_clr) | int_set;
        // Request bit drops once its pending flag is cleared
        s_nxt.swreq = s_nxt.swreq & ~pend_clr;
        // RL7 event mask gates events; RL8 one pulse, pending untouched
        s_nxt.evt = trig & s_r.emask;

        // RL16 grouped processor interrupts
        s_nxt.irq_1_0 = |s_nxt.pend[1:0];
        s_nxt.irq_3_2 = |s_nxt.pend[3:2];
        s_nxt.irq_17_4 = |s_nxt.pend[17:4];
        s_nxt.irq_18 = s_nxt.pend[18];
        s_nxt.irq_19 = s_nxt.pend[19];
        // RL11 wake sources
        s_nxt.wake_irq = |s_nxt.pend;
        s_nxt.wake_evt = |s_nxt.evt;

        // ************************************************************
        // Sticky status, cleared by read; a new set wins the clear
        // ************************************************************
        st_set[`ST_PEND_SET] = |(int_set & ~s_r.pend);
        st_set[`ST_EVENT_OUT] = |s_nxt.evt;
        st_set[`ST_SOFT_REQ] = |sw_fire;
        s_nxt.status = (s_r.status & ~st_clr) | st_set;
        s_nxt.st_irq = |(s_nxt.status & s_nxt.stmask);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // RL18 every line bit starts at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign irq_lines_1_0 = s_r.irq_1_0;
    assign irq_lines_3_2 = s_r.irq_3_2;
    assign irq_lines_17_4 = s_r.irq_17_4;
    assign irq_supply_monitor = s_r.irq_18;
    assign irq_wake_timer = s_r.irq_19;
    assign line_event_pulse = s_r.evt;
    assign wake_irq_request = s_r.wake_irq;
    assign wake_event_pulse = s_r.wake_evt;
    assign status_irq = s_r.st_irq;

endmodule // external_line_event_ctrl

/* shared/line_event_defs.svh */
// Offsets, field positions, reset values and codes of the line controller.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LINE_EVENT_DEFS_SVH
`define LINE_EVENT_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define LINE_COUNT 20
`define PORT_A_LINES 16
`define PORT_B_LINES 2

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_INTERRUPT_MASK 8'h00
`define OFS_EVENT_MASK 8'h04
`define OFS_RISING_EDGE_ENABLE 8'h08
`define OFS_FALLING_EDGE_ENABLE 8'h0C
`define OFS_SOFTWARE_REQUEST 8'h10
`define OFS_PENDING_FLAGS 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_STATUS_MASK 8'h1C

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_LINE_REG 20'h00000
`define RST_STATUS 3'h0

// ****************************************************************
// Status bit positions
// ****************************************************************
`define ST_PEND_SET 0
`define ST_EVENT_OUT 1
`define ST_SOFT_REQ 2
`define ST_WIDTH 3

// ****************************************************************
// Bus response codes
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* shared/line_event_pkg.sv */
// Types shared by the line controller design.
// Assumes line_event_defs.svh is on the include path.
package line_event_pkg;
    `include "line_event_defs.svh"

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } rd_state_t;
endpackage

/* testbench/line_event_monitor.sv */
// Port checks for the line controller, bound to its top module.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/10ps
module line_event_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic irq_lines_1_0,
    input wire logic irq_lines_3_2,
    input wire logic irq_lines_17_4,
    input wire logic irq_supply_monitor,
    input wire logic irq_wake_timer,
    input wire logic [19:0] line_event_pulse,
    input wire logic wake_irq_request,
    input wire logic wake_event_pulse
);
    // ****
    // Properties
    // ****
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wake_or:
        assert property (wake_irq_request == (irq_lines_1_0 | irq_lines_3_2
            | irq_lines_17_4 | irq_supply_monitor | irq_wake_timer))
        else $error("wake level differs from line groups");
    a_irq_clear_write:
        assert property ($fell(wake_irq_request) |->
            s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt withdrawn without a write");
    a_event_single:
        assert property (line_event_pulse != 20'h00000 |=>
            (line_event_pulse & $past(line_event_pulse)) == 20'h00000)
        else $error("event pulse longer than one cycle");
    a_event_wake:
        assert property (line_event_pulse != 20'h00000 |->
            ##[0:1] wake_event_pulse)
        else $error("event gave no wake pulse");
    a_write_answer:
        assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer:
        assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_read_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_reserved_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:20] == 12'h000)
        else $error("reserved bits read nonzero");
endmodule // line_event_monitor

bind external_line_event_ctrl line_event_monitor mon_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .irq_lines_1_0, .irq_lines_3_2,
    .irq_lines_17_4, .irq_supply_monitor, .irq_wake_timer,
    .line_event_pulse, .wake_irq_request, .wake_event_pulse);

/* testbench/irq_sink_model.sv */
// Stand-in for the wake logic that takes event pulses from the controller.
// Assumes pulses are synchronous to aclk; clear empties its record.
`timescale 1ns/10ps
module irq_sink_model (
    input wire logic aclk,
    input wire logic clear,
    input wire logic [19:0] line_event_pulse,
    input wire logic wake_event_pulse,
    output logic [19:0] seen,
    output int wake_count
);
    always_ff @(posedge aclk) begin
        if (clear) begin
            seen <= 20'h00000;
            wake_count <= 0;
        end else begin
            seen <= seen | line_event_pulse;
            wake_count <= wake_count + int'(wake_event_pulse);
        end
    end
endmodule // irq_sink_model

/* testbench/testbench.sv */
// Self-checking bench: AXI4-Lite master, pin driver and a line model.
// Assumes the design, package and sink model are compiled before it.
`timescale 1ns/10ps
`include "line_event_defs.svh"
module testbench;
    import line_event_pkg::*;
    logic aclk, aresetn = 1'b0, clear = 1'b1;
    logic [19:0] pins = 20'h00000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq_lines_1_0, irq_lines_3_2, irq_lines_17_4;
    logic irq_supply_monitor, irq_wake_timer, wake_irq_request;
    logic wake_event_pulse, status_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [19:0] line_event_pulse, seen;
    logic [19:0] im_m, em_m, rise_m, fall_m, pend_m, ev_m;
    logic [2:0] st_m, sm_m;
    int wake_m, wake_count, fail_count, num_checks;
    // pin-select clock on; lines wired fixed
    wire logic [15:0] port_a_pin = pins[15:0];
    wire logic [1:0] port_b_pin = pins[17:16];
    wire logic supply_monitor_out = pins[18];
    wire logic basic_wake_timer_event = pins[19];
    wire logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    wire logic [3:0] s_axi_wstrb = 4'hF;
    external_line_event_ctrl dut_u (.aclk, .aresetn, .port_a_pin,
        .port_b_pin, .supply_monitor_out, .basic_wake_timer_event,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_lines_1_0,
        .irq_lines_3_2, .irq_lines_17_4, .irq_supply_monitor,
        .irq_wake_timer, .line_event_pulse, .wake_irq_request,
        .wake_event_pulse, .status_irq);
    irq_sink_model sink_u (.aclk, .clear, .line_event_pulse,
        .wake_event_pulse, .seen, .wake_count);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({32'h0, er}, {32'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk({er, e}, {s_axi_rresp, s_axi_rdata});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic grp();
        // Sample at the next edge: outputs launched by the last one
        @(posedge aclk);
        chk({27'h0, |(st_m & sm_m), pend_m[19], pend_m[18], |pend_m[17:4],
            |pend_m[3:2], |pend_m[1:0], |pend_m}, {27'h0, status_irq,
            irq_wake_timer, irq_supply_monitor, irq_lines_17_4,
            irq_lines_3_2, irq_lines_1_0, wake_irq_request});
    endtask
    task automatic look();
        rd(8'h14, {12'h0, pend_m}, `RESP_OKAY);
        chk({14'h0, ev_m}, {14'h0, seen});
        chk(34'(wake_m), 34'(wake_count));
        grp();
    endtask
    task automatic fire(input logic [19:0] hit);
        if ((hit & im_m & ~pend_m) != 20'h0) st_m[0] = 1'b1;
        if ((hit & em_m) != 20'h0) begin
            st_m[1] = 1'b1;
            wake_m++;
        end
        pend_m |= hit & im_m;
        ev_m |= hit & em_m;
    endtask
    task automatic step(input logic [19:0] nv);
        fire((nv & ~pins & rise_m) | (~nv & pins & fall_m));
        pins <= nv;
        repeat (6) @(posedge aclk);
        look();
    endtask
    task automatic clr(input logic [19:0] k);
        wr(8'h14, {12'h0, k}, `RESP_OKAY);
        pend_m &= ~k;
        look();
    endtask
    task automatic cfg(input logic [19:0] i, e, r, f);
        im_m = i;
        em_m = e;
        rise_m = r;
        fall_m = f;
        wr(8'h00, {12'h0, i}, `RESP_OKAY);
        wr(8'h04, {12'h0, e}, `RESP_OKAY);
        wr(8'h08, {12'h0, r}, `RESP_OKAY);
        wr(8'h0C, {12'h0, f}, `RESP_OKAY);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial begin
        logic [31:0] w;
        {pend_m, ev_m, st_m, sm_m, wake_m} = '0;
        void'($urandom(32'h12B9BBC0));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        clear <= 1'b0;
        @(posedge aclk);
        for (int a = 0; a <= 32; a += 4) begin
            rd(8'(a), 32'h0, a == 32 ? `RESP_SLVERR : `RESP_OKAY);
        end
        wr(8'h24, 32'hFFFFFFFF, `RESP_SLVERR);
        wr(8'h18, 32'hFFFFFFFF, `RESP_OKAY);
        wr(8'h1C, 32'h7, `RESP_OKAY);
        sm_m = 3'h7;
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            wr(8'(i * 4), w, `RESP_OKAY);
            rd(8'(i * 4), w & 32'h000FFFFF, `RESP_OKAY);
        end
        $display("test registers done");
        cfg(20'hFFFFF, 20'h0, 20'($urandom), 20'($urandom));
        step(20'hFFFFF);
        clr(20'($urandom));
        clr(20'hFFFFF);
        step(20'h00000);
        clr(20'hFFFFF);
        $display("test edges done");
        cfg(20'h0, 20'h0, 20'hFFFFF, 20'hFFFFF);
        step(20'hFFFFF);
        cfg(20'hFFFFF, 20'h0, 20'hFFFFF, 20'hFFFFF);
        step(20'h00000);
        clr(20'hFFFFF);
        cfg(20'h0, 20'($urandom), 20'hFFFFF, 20'h0);
        step(20'hFFFFF);
        $display("test masks and events done");
        rd(8'h18, {29'h0, st_m}, `RESP_OKAY);
        st_m = 3'h0;
        wr(8'h1C, 32'h0, `RESP_OKAY);
        sm_m = 3'h0;
        w = $urandom;
        cfg(w[19:0], w[31:12], 20'h0, 20'h0);
        w = $urandom;
        fire(w[19:0]);
        if (w[19:0] != 20'h0) st_m[2] = 1'b1;
        wr(8'h10, {12'h0, w[19:0]}, `RESP_OKAY);
        look();
        wr(8'h1C, 32'h7, `RESP_OKAY);
        sm_m = 3'h7;
        grp();
        rd(8'h18, {29'h0, st_m}, `RESP_OKAY);
        st_m = 3'h0;
        grp();
        $display("test software requests done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        summarize();
    end
endmodule // testbench
